/* bench/pss_top_tb.sv */
// self-checking bench for the summary status upper half
`timescale 1ns/100ps
module pss_top_tb;
  import pss_pkg::*;
  // ****************
  // signals
  // ****************
  logic mclk = 1'b0; // 125 MHz device clock
  logic srst = 1'b1; // held for six cycles
  logic rd_strobe = 1'b0; // one-cycle read pulse
  logic [4:0] rd_addr = 5'h00; // address of the read
  logic crossover_auto_enable = 1'b0;
  logic crossover_force = 1'b0;
  logic auto_swap_state = 1'b0;
  logic [4:0] evts = 5'h00; // rx err, polarity, false carrier, page, fault
  logic [1:0] pins = 2'h0; // descrambler lock, signal detect
  logic [15:6] summary_upper_q;
  logic crossover_swapped;
  logic [15:6] w; // expected summary word
  logic x; // expected pair state
  int error_cnt = 0;
  int checks_done = 0;
  int bitpos[5] = '{13, 12, 11, 8, 6}; // bit fed by each event
  logic [4:0] clr[5] = '{5'h15, 5'h1a, 5'h14, 5'h06, 5'h01}; // clearing reads

  always #4 mclk = ~mclk;

  pss_top u_pss_top (.mclk(mclk), .srst(srst), .rd_strobe(rd_strobe), .rd_addr(rd_addr),
    .crossover_auto_enable(crossover_auto_enable), .crossover_force(crossover_force),
    .auto_swap_state(auto_swap_state), .rx_error_evt(evts[0]), .polarity_inv_evt(evts[1]),
    .false_carrier_evt(evts[2]), .page_rx_evt(evts[3]), .remote_fault_evt(evts[4]),
    .sig_detect_pin(pins[0]), .descr_lock_pin(pins[1]),
    .summary_upper_q(summary_upper_q), .crossover_swapped(crossover_swapped));

  // ****************
  // tasks
  // ****************
  // inputs move on the falling edge, away from sampling
  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  // management read: strobe stands for exactly one edge
  task automatic rd(input logic [4:0] a);
    rd_strobe = 1'b1;
    rd_addr = a;
    tick(1);
    rd_strobe = 1'b0;
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // ****************
  // watchdog
  // ****************
  // run needs about 175 cycles; allow far more
  initial begin
    #40000;
    error_cnt++;
    wrap_up();
  end

  // ****************
  // main sequence
  // ****************
  initial begin
    tick(6);
    srst = 1'b0;
    tick(3);
    chk(summary_upper_q, 10'h000);
    // every enable, force and auto choice
    for (int k = 0; k < 8; k++) begin
      {crossover_auto_enable, crossover_force, auto_swap_state} = k[2:0];
      tick(3);
      x = crossover_force | (crossover_auto_enable & auto_swap_state);
      w = '0;
      w[14] = x;
      chk({9'h000, crossover_swapped}, {9'h000, x});
      chk(summary_upper_q, w);
    end
    {crossover_auto_enable, crossover_force, auto_swap_state} = 3'h0;
    tick(3);
    // each sticky bit: own read clears, summary read and the next bit's clearing read keep it
    for (int i = 0; i < 5; i++) begin
      w = '0;
      w[bitpos[i]] = 1'b1;
      evts[i] = 1'b1;
      tick(1);
      evts[i] = 1'b0;
      tick(3);
      chk(summary_upper_q, w);
      rd(5'h10);
      tick(3);
      chk(summary_upper_q, w);
      rd(clr[(i + 1) % 5]);
      tick(3);
      chk(summary_upper_q, w);
      rd(clr[i]);
      tick(3);
      chk(summary_upper_q, 10'h000);
    end
    // event in the same cycle as its clearing read: set wins
    evts[0] = 1'b1;
    rd(5'h15);
    evts[0] = 1'b0;
    tick(3);
    w = '0;
    w[13] = 1'b1;
    chk(summary_upper_q, w);
    rd(5'h15);
    tick(3);
    // latch-low bits start low and need a summary read to track
    pins = 2'h3;
    tick(6);
    chk(summary_upper_q, 10'h000);
    rd(5'h10);
    tick(6);
    w = '0;
    w[10] = 1'b1;
    w[9] = 1'b1;
    chk(summary_upper_q, w);
    for (int j = 0; j < 2; j++) begin
      pins[j] = 1'b0;
      tick(6);
      w[10 - j] = 1'b0;
      chk(summary_upper_q, w);
      pins[j] = 1'b1;
      tick(6);
      chk(summary_upper_q, w);
      rd(5'h10);
      tick(6);
      w[10 - j] = 1'b1;
      chk(summary_upper_q, w);
    end
    wrap_up();
  end
endmodule

/* hw/pss_latch_low.sv */
// latch-low status: drops with the source, tracks again after a read
`timescale 1ns/100ps
`include "pss_map.svh"
module pss_latch_low
  import pss_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic src, // synchronised live indication
  input wire logic rd, // read of the holding register
  output logic stat_q
);
  logic held_q; // a low was seen and not yet read
  // low capture wins over a read in the same cycle
  always_ff @(posedge mclk) begin
    if (srst) begin
      held_q <= 1'b0;
    end else if (!src) begin
      held_q <= 1'b1;
    end else if (rd) begin
      held_q <= 1'b0;
    end
  end
  // reported value: held low, else live source
  always_ff @(posedge mclk) begin
    if (srst) begin
      stat_q <= `PSS_RST_LATCH_LOW;
    end else begin
      stat_q <= src && !(held_q && !rd);
    end
  end
endmodule

/* hw/pss_map.svh */
// register offsets, bit positions and reset values for the summary status upper half
`ifndef PSS_MAP_SVH
`define PSS_MAP_SVH
`define PSS_OFF_SUMMARY 5'h10
`define PSS_OFF_NEG_EXP 5'h06
`define PSS_OFF_BASIC_STATUS 5'h01
`define PSS_OFF_TENBASE_SC 5'h1a
`define PSS_OFF_FALSE_CARRIER 5'h14
`define PSS_OFF_RX_ERROR 5'h15
`define PSS_BIT_RSVD_HI 15
`define PSS_BIT_CROSSOVER 14
`define PSS_BIT_RX_ERR 13
`define PSS_BIT_POLARITY 12
`define PSS_BIT_FALSE_CARRIER 11
`define PSS_BIT_SIG_DET 10
`define PSS_BIT_DESCR_LOCK 9
`define PSS_BIT_PAGE_RX 8
`define PSS_BIT_RSVD_LO 7
`define PSS_BIT_REMOTE_FAULT 6
`define PSS_RST_STICKY 1'b0
`define PSS_RST_LATCH_LOW 1'b0
`endif

/* hw/pss_pkg.sv */
// types shared by the summary status upper half
package pss_pkg;
  typedef logic [4:0] pss_addr_t; // management register address
  typedef logic [9:0] pss_upper_t; // bits 15 down to 6 of the summary word
  typedef enum {PSS_XO_NORMAL, PSS_XO_SWAPPED} pss_xo_e; // pair assignment
endpackage

/* hw/pss_sticky.sv */
// sticky high flag: set by an event, cleared by a read strobe
`timescale 1ns/100ps
`include "pss_map.svh"
module pss_sticky
  import pss_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic set_evt, // hardware event
  input wire logic clr_rd, // clearing read strobe
  output logic flag_q
);
  // set wins over a clear in the same cycle so no event is lost
  always_ff @(posedge mclk) begin
    if (srst) begin
      flag_q <= `PSS_RST_STICKY;
    end else if (set_evt) begin
      flag_q <= 1'b1;
    end else if (clr_rd) begin
      flag_q <= 1'b0;
    end
  end
endmodule

/* hw/pss_top.sv */
// summary status register, upper bits 15 to 6, with read-clear wiring
`timescale 1ns/100ps
`include "pss_map.svh"
//
// Operation
// - reserved bits 15 and 7 read zero
// - bit 14 set when pairs swapped
// - crossover follows enable, force, auto algorithm
// - bit 13 latches rx error, cleared by 0x15 read
// - bit 12 mirrors polarity status bit
// - polarity clears on tenbase read only
// - bit 11 latches false carrier, cleared by 0x14 read
// - bit 10 latch-low signal detect, reset zero
// - bit 9 latch-low descrambler lock, reset zero
// - bit 8 page received, cleared by 0x06 read
// - summary read keeps page received flag
// - bit 6 remote fault, cleared by 0x01 read
module pss_top
  import pss_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic rd_strobe, // one-cycle management read
  input wire logic [4:0] rd_addr, // address of that read
  input wire logic crossover_auto_enable, // control bit, same domain
  input wire logic crossover_force, // control bit, same domain
  input wire logic auto_swap_state, // auto algorithm current choice
  input wire logic rx_error_evt, // receive error pulse
  input wire logic polarity_inv_evt, // inverted polarity detected pulse
  input wire logic false_carrier_evt, // false carrier pulse
  input wire logic sig_detect_pin, // pmd signal detect, async
  input wire logic descr_lock_pin, // pmd descrambler lock, async
  input wire logic page_rx_evt, // new link code word page
  input wire logic remote_fault_evt, // partner remote fault
  output logic [15:6] summary_upper_q, // upper half of read word
  output logic crossover_swapped // live pair state
);
  // ************************************************************
  // address decode
  // ************************************************************
  // decode used for every clearing read
  function automatic logic rd_hit(input logic stb, input pss_addr_t a, input pss_addr_t off);
    rd_hit = stb && (a == off);
  endfunction
  logic rd_summary; // read of the summary word
  logic rd_rx_err; // read of the receive error counter
  logic rd_fc; // read of the false carrier counter
  logic rd_tenbase; // read of the tenbase status control
  logic rd_neg_exp; // read of negotiation expansion
  logic rd_basic; // read of basic status
  assign rd_summary = rd_hit(rd_strobe, rd_addr, `PSS_OFF_SUMMARY);
  assign rd_rx_err = rd_hit(rd_strobe, rd_addr, `PSS_OFF_RX_ERROR);
  assign rd_fc = rd_hit(rd_strobe, rd_addr, `PSS_OFF_FALSE_CARRIER);
  assign rd_tenbase = rd_hit(rd_strobe, rd_addr, `PSS_OFF_TENBASE_SC);
  assign rd_neg_exp = rd_hit(rd_strobe, rd_addr, `PSS_OFF_NEG_EXP);
  assign rd_basic = rd_hit(rd_strobe, rd_addr, `PSS_OFF_BASIC_STATUS);

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  logic [1:0] sd_sync_q; // signal detect two stages
  logic [1:0] dl_sync_q; // descrambler lock two stages
  // first stage feeds only the second
  always_ff @(posedge mclk) begin
    if (srst) begin
      sd_sync_q <= 2'h0;
      dl_sync_q <= 2'h0;
    end else begin
      sd_sync_q <= {sd_sync_q[0], sig_detect_pin};
      dl_sync_q <= {dl_sync_q[0], descr_lock_pin};
    end
  end

  // ************************************************************
  // crossover state
  // ************************************************************
  pss_xo_e xo_d; // next pair assignment
  // force overrides auto; auto tracks the algorithm live
  always_comb begin
    if (crossover_force) begin
      xo_d = PSS_XO_SWAPPED;
    end else if (crossover_auto_enable) begin
      xo_d = auto_swap_state ? PSS_XO_SWAPPED : PSS_XO_NORMAL;
    end else begin
      xo_d = PSS_XO_NORMAL;
    end
  end
  assign crossover_swapped = (xo_d == PSS_XO_SWAPPED);

  // ************************************************************
  // sticky and latch-low cells
  // ************************************************************
  logic rx_err_q; // receive error latch
  logic pol_q; // polarity status copy
  logic fc_q; // false carrier latch
  logic sd_q; // signal detect latch-low
  logic dl_q; // descrambler lock latch-low
  logic page_q; // page received copy
  logic rf_q; // remote fault
  // receive error latch clears on a read of the error counter
  pss_sticky u_rx_err (
    .mclk(mclk),
    .srst(srst),
    .set_evt(rx_error_evt), // receive error pulse
    .clr_rd(rd_rx_err), // counter read clears
    .flag_q(rx_err_q)
  );
  // polarity only clears on a tenbase read, never a summary read
  pss_sticky u_pol (
    .mclk(mclk),
    .srst(srst),
    .set_evt(polarity_inv_evt), // inverted polarity pulse
    .clr_rd(rd_tenbase), // tenbase status read clears
    .flag_q(pol_q)
  );
  // false carrier latch clears on a read of its counter
  pss_sticky u_fc (
    .mclk(mclk),
    .srst(srst),
    .set_evt(false_carrier_evt), // false carrier pulse
    .clr_rd(rd_fc), // counter read clears
    .flag_q(fc_q)
  );
  // page copy ignores summary reads
  pss_sticky u_page (
    .mclk(mclk),
    .srst(srst),
    .set_evt(page_rx_evt), // new page pulse
    .clr_rd(rd_neg_exp), // expansion read clears
    .flag_q(page_q)
  );
  // remote fault clears on a basic status read or reset
  pss_sticky u_rf (
    .mclk(mclk),
    .srst(srst),
    .set_evt(remote_fault_evt), // partner fault report
    .clr_rd(rd_basic), // basic status read clears
    .flag_q(rf_q)
  );
  // latch-low bits rearm on a summary read
  pss_latch_low u_sd (
    .mclk(mclk),
    .srst(srst),
    .src(sd_sync_q[1]), // second stage only
    .rd(rd_summary), // summary read rearms
    .stat_q(sd_q)
  );
  // same rearm for the descrambler lock; a lock lost and regained between
  // two reads still shows as zero, which is the point of a latch-low bit
  pss_latch_low u_dl (
    .mclk(mclk),
    .srst(srst),
    .src(dl_sync_q[1]), // second stage only
    .rd(rd_summary), // summary read rearms
    .stat_q(dl_q)
  );

  // ************************************************************
  // read word assembly
  // ************************************************************
  // registered so the word is stable between edges, reloaded from the cells on every edge
  always_ff @(posedge mclk) begin
    if (srst) begin
      summary_upper_q <= 10'h000;
    end else begin
      summary_upper_q[`PSS_BIT_RSVD_HI] <= 1'b0;
      summary_upper_q[`PSS_BIT_CROSSOVER] <= crossover_swapped;
      summary_upper_q[`PSS_BIT_RX_ERR] <= rx_err_q;
      summary_upper_q[`PSS_BIT_POLARITY] <= pol_q;
      summary_upper_q[`PSS_BIT_FALSE_CARRIER] <= fc_q;
      summary_upper_q[`PSS_BIT_SIG_DET] <= sd_q;
      summary_upper_q[`PSS_BIT_DESCR_LOCK] <= dl_q;
      summary_upper_q[`PSS_BIT_PAGE_RX] <= page_q;
      summary_upper_q[`PSS_BIT_RSVD_LO] <= 1'b0;
      summary_upper_q[`PSS_BIT_REMOTE_FAULT] <= rf_q;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  sequence s_rx_set;
    rx_error_evt;
  endsequence
  sequence s_no_clear;
    !rd_rx_err [*2];
  endsequence
  a_reserved_zero: assert property (@(posedge mclk) disable iff (srst)
    !summary_upper_q[15] && !summary_upper_q[7]) else $error("reserved bit nonzero");
  a_force_swap: assert property (@(posedge mclk) disable iff (srst)
    crossover_force |-> ##1 summary_upper_q[14]) else $error("force did not swap");
  a_rx_err_latch: assert property (@(posedge mclk) disable iff (srst)
    s_rx_set ##0 s_no_clear |-> ##2 summary_upper_q[13]) else $error("rx error not latched");
  a_rx_err_clear: assert property (@(posedge mclk) disable iff (srst)
    rd_rx_err && !rx_error_evt |=> !rx_err_q) else $error("rx error not cleared");
  a_pol_keep: assert property (@(posedge mclk) disable iff (srst)
    pol_q && !rd_tenbase |=> pol_q) else $error("polarity lost");
  a_fc_clear: assert property (@(posedge mclk) disable iff (srst)
    rd_fc && !false_carrier_evt |=> !fc_q) else $error("false carrier not cleared");
  a_page_keep: assert property (@(posedge mclk) disable iff (srst)
    page_q && !rd_neg_exp |=> page_q) else $error("page flag lost");
  a_rf_clear: assert property (@(posedge mclk) disable iff (srst)
    rd_basic && !remote_fault_evt |=> !rf_q) else $error("remote fault not cleared");
  a_sd_low: assert property (@(posedge mclk) disable iff (srst)
    !sd_sync_q[1] |=> !sd_q ##1 !summary_upper_q[10]) else $error("signal detect not low");

  // ************************************************************
  // checks: crossover
  // ************************************************************
  // comb path, so the status tracks the algorithm with no lag
  a_xo_live: assert property (@(posedge mclk) disable iff (srst)
    crossover_auto_enable && !crossover_force |-> crossover_swapped == auto_swap_state)
    else $error("auto crossover not live");
  a_xo_normal: assert property (@(posedge mclk) disable iff (srst)
    !crossover_auto_enable && !crossover_force |-> !crossover_swapped)
    else $error("crossover not normal");
  a_xo_clear: assert property (@(posedge mclk) disable iff (srst)
    !crossover_swapped |=> !summary_upper_q[`PSS_BIT_CROSSOVER])
    else $error("swap bit stuck high");

  // ************************************************************
  // checks: sticky bits
  // ************************************************************
  // a set reaches the flag, then the read word one edge later
  sequence s_pol_copy;
    pol_q ##1 summary_upper_q[`PSS_BIT_POLARITY];
  endsequence
  sequence s_page_copy;
    page_q ##1 summary_upper_q[`PSS_BIT_PAGE_RX];
  endsequence
  sequence s_rf_copy;
    rf_q ##1 summary_upper_q[`PSS_BIT_REMOTE_FAULT];
  endsequence
  // set wins over a clearing read, so only a clean read may drop a flag
  a_rx_err_keep: assert property (@(posedge mclk) disable iff (srst)
    rx_err_q && !rd_rx_err |=> rx_err_q)
    else $error("rx error flag lost");
  a_pol_set: assert property (@(posedge mclk) disable iff (srst)
    polarity_inv_evt |=> s_pol_copy)
    else $error("polarity not copied");
  a_pol_clear: assert property (@(posedge mclk) disable iff (srst)
    rd_tenbase && !polarity_inv_evt |=> !pol_q)
    else $error("polarity not cleared");
  a_fc_latch: assert property (@(posedge mclk) disable iff (srst)
    false_carrier_evt |=> fc_q)
    else $error("false carrier not latched");
  a_fc_keep: assert property (@(posedge mclk) disable iff (srst)
    fc_q && !rd_fc |=> fc_q)
    else $error("false carrier flag lost");
  a_page_set: assert property (@(posedge mclk) disable iff (srst)
    page_rx_evt |=> s_page_copy)
    else $error("page flag not copied");
  a_page_clear: assert property (@(posedge mclk) disable iff (srst)
    rd_neg_exp && !page_rx_evt |=> !page_q)
    else $error("page flag not cleared");
  a_rf_set: assert property (@(posedge mclk) disable iff (srst)
    remote_fault_evt |=> s_rf_copy)
    else $error("remote fault not copied");
  a_rf_keep: assert property (@(posedge mclk) disable iff (srst)
    rf_q && !rd_basic |=> rf_q)
    else $error("remote fault flag lost");

  // ************************************************************
  // checks: latch-low bits
  // ************************************************************
  // a low must hold until the summary word is read
  sequence s_dl_drop;
    !dl_q ##1 !summary_upper_q[`PSS_BIT_DESCR_LOCK];
  endsequence
  a_sd_hold: assert property (@(posedge mclk) disable iff (srst)
    !sd_q && !rd_summary |=> !sd_q)
    else $error("signal detect rose unread");
  a_sd_rearm: assert property (@(posedge mclk) disable iff (srst)
    sd_sync_q[1] && rd_summary |=> sd_q)
    else $error("signal detect not rearmed");
  a_dl_low: assert property (@(posedge mclk) disable iff (srst)
    !dl_sync_q[1] |=> s_dl_drop)
    else $error("descrambler lock not low");
  a_dl_hold: assert property (@(posedge mclk) disable iff (srst)
    !dl_q && !rd_summary |=> !dl_q)
    else $error("descrambler lock rose unread");
  a_dl_rearm: assert property (@(posedge mclk) disable iff (srst)
    dl_sync_q[1] && rd_summary |=> dl_q)
    else $error("descrambler lock not rearmed");

  // ************************************************************
  // checks: read word copies
  // ************************************************************
  // each status bit reaches the read word one edge after its cell
  a_word_rx_err: assert property (@(posedge mclk) disable iff (srst)
    1'b1 |=> summary_upper_q[`PSS_BIT_RX_ERR] == $past(rx_err_q))
    else $error("rx error bit mismatch");
  a_word_fc: assert property (@(posedge mclk) disable iff (srst)
    1'b1 |=> summary_upper_q[`PSS_BIT_FALSE_CARRIER] == $past(fc_q))
    else $error("false carrier bit mismatch");
  a_word_sd: assert property (@(posedge mclk) disable iff (srst)
    1'b1 |=> summary_upper_q[`PSS_BIT_SIG_DET] == $past(sd_q))
    else $error("signal detect bit mismatch");
  a_word_dl: assert property (@(posedge mclk) disable iff (srst)
    1'b1 |=> summary_upper_q[`PSS_BIT_DESCR_LOCK] == $past(dl_q))
    else $error("descrambler lock bit mismatch");
  // reset clears the whole word in one edge
  a_summary_reset: assert property (@(posedge mclk)
    srst |=> summary_upper_q == 10'h000)
    else $error("summary word not reset");
endmodule
